//--- eqcb_pkg.sv
// Package: register map, field layout and reset values of the channel A equalizer coefficient bank
package eqcb_pkg;
  // ==========================================================
  // Register indices (word offsets; byte address = 4 * index)
  localparam logic [11:0] IDX_TAP0 = 12'h418;
  localparam logic [11:0] IDX_TAP1 = 12'h41A;
  localparam logic [11:0] IDX_TAP2 = 12'h41C;
  localparam logic [11:0] IDX_TAP3 = 12'h41E;
  localparam logic [11:0] IDX_CENTER = 12'h420;
  localparam logic [11:0] IDX_TAP5 = 12'h423;
  localparam logic [11:0] IDX_CFG = 12'h400;
  localparam logic [11:0] IDX_CTRL = 12'h401;
  // ==========================================================
  // Field widths and positions
  localparam int SIDE_W = 12;
  localparam int SIDE_REG_W = 16;
  localparam int CENTER_W = 18;
  localparam int CENTER_REG_W = 24;
  localparam int NUM_SIDE = 5;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SCW_LSB = 2;
  localparam int CFG_MERGE_BIT = 5;
  localparam int CFG_SHARE_BIT = 6;
  localparam int CTRL_LINK_BIT = 0;
  localparam int CTRL_FLAG_BIT = 1;
  localparam logic [2:0] SCW_MAX = 3'h6;
  // ==========================================================
  // Reset values
  localparam logic [15:0] SIDE_RESET = 16'h0000;
  localparam logic [23:0] CENTER_RESET = 24'h000000;
  localparam logic [7:0] CFG_RESET = 8'h00;
endpackage : eqcb_pkg

//--- eqcb_bank.sv
// Module: channel A equalizer coefficient bank, taps one to six, with Wishbone slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RL1] Side taps hold a signed 12-bit value in bits 11:0, bits 15:12 reserved.
// [RL2] Register n drives tap n+1 of channel A, or of the merged filter when merging.
// [RL3] The fifth coefficient is the centre tap, signed 18 bits in 17:0, bits 23:18 reserved.
// [RL4] Readback of any coefficient shows its top coefficient bit as zero, other bits as stored.
// [RL5] Taps sit at 0x418, 0x41A, 0x41C, 0x41E, 0x420, 0x423 and reset to zero.
// [RL6] With sharing set, channel B uses the channel A coefficients, else its own set.
// [RL7] Side-tap LSB weight is two to the (side weight minus sixteen), weight 0 to 6.
// [RL8] Software changes coefficients and configuration only while the serial link is off.
// [RL9] Software sets the merge control whenever the converter runs single channel.
module eqcb_bank #(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Channel B own coefficient set (from the channel B bank)
  input wire logic [eqcb_pkg::SIDE_W*eqcb_pkg::NUM_SIDE-1:0] chb_side_i,
  input wire logic [eqcb_pkg::CENTER_W-1:0] chb_center_i,
  // Coefficients to the filter datapath
  output logic [eqcb_pkg::SIDE_W*eqcb_pkg::NUM_SIDE-1:0] cha_side_o,
  output logic [eqcb_pkg::CENTER_W-1:0] cha_center_o,
  output logic [eqcb_pkg::SIDE_W*eqcb_pkg::NUM_SIDE-1:0] chb_side_o,
  output logic [eqcb_pkg::CENTER_W-1:0] chb_center_o,
  // Filter configuration to the datapath
  output logic [1:0] filter_mode_o,
  output logic [2:0] side_coef_weight_o,
  output logic filter_merge_o,
  output logic coef_share_b_with_a_o,
  output logic serial_link_enable_o,
  output logic cfg_write_while_link_o
);

  // ==========================================================
  // Elaboration checks
  // The decode reads address bits 13:2, so a narrower bus cannot reach the bank
  if (ADDR_W < 14) begin : g_addr_w_check
    $error("eqcb_bank: ADDR_W must be at least 14");
  end
  // Coefficients must fit the register words that hold them
  if (eqcb_pkg::SIDE_W > eqcb_pkg::SIDE_REG_W
      || eqcb_pkg::CENTER_W > eqcb_pkg::CENTER_REG_W) begin : g_field_check
    $error("eqcb_bank: coefficient wider than its register word");
  end

  // ==========================================================
  // Storage
  // Reserved bits are stored and read back as written; only the top coefficient bit is hidden
  logic [eqcb_pkg::SIDE_REG_W-1:0] side_q [eqcb_pkg::NUM_SIDE];
  logic [eqcb_pkg::CENTER_REG_W-1:0] center_q;
  logic [7:0] cfg_q;
  logic link_en_q;
  logic write_in_link_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdata_q;

  // ==========================================================
  // Decode
  logic [11:0] idx;
  logic req;
  logic hit_any;
  logic [2:0] side_sel;
  logic side_hit;

  // Map a register index to its side-tap slot; slot NUM_SIDE means none
  function automatic logic [2:0] side_slot(input logic [11:0] i);
    case (i)
      eqcb_pkg::IDX_TAP0: side_slot = 3'h0;
      eqcb_pkg::IDX_TAP1: side_slot = 3'h1;
      eqcb_pkg::IDX_TAP2: side_slot = 3'h2;
      eqcb_pkg::IDX_TAP3: side_slot = 3'h3;
      eqcb_pkg::IDX_TAP5: side_slot = 3'h4;
      default: side_slot = 3'h5;
    endcase
  endfunction : side_slot

  // Merge byte lanes of a write into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    lane_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        lane_merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction : lane_merge

  // Readback view of a stored word: the coefficient's top bit reads as zero
  function automatic logic [31:0] read_view(input logic [31:0] word, input int msb);
    read_view = word;
    read_view[msb] = 1'b0;
  endfunction : read_view

  // Word address is the index; low two byte bits are ignored
  assign idx = wb_adr_i[13:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign side_sel = side_slot(idx);
  assign side_hit = (side_sel != 3'h5);
  assign hit_any = side_hit || (idx == eqcb_pkg::IDX_CENTER) || (idx == eqcb_pkg::IDX_CFG)
                   || (idx == eqcb_pkg::IDX_CTRL);

  // ==========================================================
  // Side-tap registers
  // [RL1] 16-bit word, coefficient in 11:0
  // [RL5] reset to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < eqcb_pkg::NUM_SIDE; k++) begin
        side_q[k] <= eqcb_pkg::SIDE_RESET;
      end
    end else if (req && wb_we_i && side_hit) begin
      side_q[side_sel] <= 16'(lane_merge({16'h0000, side_q[side_sel]}, wb_dat_i, wb_sel_i));
    end
  end

  // Centre tap register
  // [RL3] 24-bit word, coefficient in 17:0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      center_q <= eqcb_pkg::CENTER_RESET;
    end else if (req && wb_we_i && idx == eqcb_pkg::IDX_CENTER) begin
      center_q <= 24'(lane_merge({8'h00, center_q}, wb_dat_i, wb_sel_i));
    end
  end

  // Configuration and link control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= eqcb_pkg::CFG_RESET;
      link_en_q <= 1'b0;
    end else if (req && wb_we_i && wb_sel_i[0]) begin
      if (idx == eqcb_pkg::IDX_CFG) begin
        cfg_q <= wb_dat_i[7:0];
      end
      if (idx == eqcb_pkg::IDX_CTRL) begin
        link_en_q <= wb_dat_i[eqcb_pkg::CTRL_LINK_BIT];
      end
    end
  end

  // Sticky flag: a filter write made while the link ran; cleared by writing one to its control bit
  // Set is tested first, so a misuse in the same cycle as a clear is never lost
  // [RL8] link off while changing; flag exposes misuse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_in_link_q <= 1'b0;
    end else if (req && wb_we_i && link_en_q && (side_hit || idx == eqcb_pkg::IDX_CENTER
                 || idx == eqcb_pkg::IDX_CFG)) begin
      write_in_link_q <= 1'b1;
    end else if (req && wb_we_i && wb_sel_i[0] && idx == eqcb_pkg::IDX_CTRL
                 && wb_dat_i[eqcb_pkg::CTRL_FLAG_BIT]) begin
      write_in_link_q <= 1'b0;
    end
  end

  // ==========================================================
  // Bus answer: one wait state, ack or err for one cycle
  // The ack cycle blocks a retake, so a held request is answered once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req && hit_any;
      err_q <= req && !hit_any;
      rdata_q <= 32'h00000000;
      if (req && !wb_we_i) begin
        // [RL4] top coefficient bit reads as zero
        if (side_hit) begin
          rdata_q <= read_view({16'h0000, side_q[side_sel]}, eqcb_pkg::SIDE_W - 1);
        end else if (idx == eqcb_pkg::IDX_CENTER) begin
          rdata_q <= read_view({8'h00, center_q}, eqcb_pkg::CENTER_W - 1);
        end else if (idx == eqcb_pkg::IDX_CFG) begin
          rdata_q <= {24'h000000, cfg_q};
        end else if (idx == eqcb_pkg::IDX_CTRL) begin
          rdata_q <= {30'h00000000, write_in_link_q, link_en_q};
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;

  // ==========================================================
  // Coefficient routing to the filter datapath
  // The filter always sees the stored top bit; only the readback hides it
  // [RL2] register n feeds tap n+1; merged filter uses the same words
  always_comb begin
    for (int k = 0; k < eqcb_pkg::NUM_SIDE; k++) begin
      cha_side_o[k*eqcb_pkg::SIDE_W +: eqcb_pkg::SIDE_W] = side_q[k][eqcb_pkg::SIDE_W-1:0];
    end
  end
  assign cha_center_o = center_q[eqcb_pkg::CENTER_W-1:0];

  // Plain mux, no pipeline: channel B follows a sharing change at once
  // [RL6] channel B borrows channel A set when sharing
  assign chb_side_o = cfg_q[eqcb_pkg::CFG_SHARE_BIT] ? cha_side_o : chb_side_i;
  assign chb_center_o = cfg_q[eqcb_pkg::CFG_SHARE_BIT] ? cha_center_o : chb_center_i;

  // [RL7] side weight clamped to 0..6, datapath scales LSB by 2^(w-16)
  assign side_coef_weight_o = (cfg_q[eqcb_pkg::CFG_SCW_LSB +: 3] > eqcb_pkg::SCW_MAX)
                              ? eqcb_pkg::SCW_MAX : cfg_q[eqcb_pkg::CFG_SCW_LSB +: 3];
  assign filter_mode_o = cfg_q[eqcb_pkg::CFG_MODE_LSB +: 2];
  // [RL9] merge is software's to set in single channel mode
  assign filter_merge_o = cfg_q[eqcb_pkg::CFG_MERGE_BIT];
  assign coef_share_b_with_a_o = cfg_q[eqcb_pkg::CFG_SHARE_BIT];
  assign serial_link_enable_o = link_en_q;
  assign cfg_write_while_link_o = write_in_link_q;

endmodule : eqcb_bank
`default_nettype wire

//--- eqcb_bank_monitor.sv
// Checker: bus timing and coefficient path relations of the bank
`timescale 1ns/1ps
`default_nettype none
module eqcb_bank_monitor #(
  parameter int ADDR_W = 14
) (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Coefficient and config outputs
  input wire logic [59:0] chb_side_i,
  input wire logic [59:0] cha_side_o,
  input wire logic [17:0] cha_center_o,
  input wire logic [59:0] chb_side_o,
  input wire logic [17:0] chb_center_o,
  input wire logic [2:0] side_coef_weight_o,
  input wire logic coef_share_b_with_a_o
);
  // ==========================================================
  // Taken request; the ack cycle itself is not a new request
  wire logic tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic wr = tk && wb_we_i && wb_sel_i == 4'hF;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_side_store: assert property (wr && wb_adr_i == 14'h1060 |=> cha_side_o[11:0] == $past(wb_dat_i[11:0]))
    else $error("side store");
  chk_tap_order: assert property (wr && wb_adr_i == 14'h108C |=> cha_side_o[59:48] == $past(wb_dat_i[11:0]))
    else $error("tap order");
  chk_center_store: assert property (wr && wb_adr_i == 14'h1080 |=> cha_center_o == $past(wb_dat_i[17:0]))
    else $error("centre store");
  chk_msb_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 14'h1068 |-> !wb_dat_o[11])
    else $error("msb read");
  chk_reset_clear: assert property ($fell(rst_i) |-> cha_side_o == 60'h0 && cha_center_o == 18'h0)
    else $error("reset clear");
  chk_unmapped_err: assert property (tk && wb_adr_i == 14'h1064 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped");
  chk_share_on: assert property (coef_share_b_with_a_o |-> chb_side_o == cha_side_o
    && chb_center_o == cha_center_o)
    else $error("share");
  chk_weight_clamp: assert property (side_coef_weight_o <= 3'h6)
    else $error("weight");
  // Main scenarios
  cov_center_wr: cover property (wr && wb_adr_i == 14'h1080);
  cov_err: cover property (wb_err_o);
  cov_share: cover property (coef_share_b_with_a_o);
endmodule : eqcb_bank_monitor
`default_nettype wire

//--- eqcb_bank_tb.sv
// Testbench: directed register and coefficient path tests of the bank
`timescale 1ns/1ps
`default_nettype none
module eqcb_bank_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, e;
  logic [13:0] wb_adr_i = 14'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'hF;
  logic [59:0] chb_side_i = 60'h123456789ABCDEF, cha_side_o, chb_side_o;
  logic [17:0] chb_center_i = 18'h15A5A, cha_center_o, chb_center_o;
  logic [1:0] filter_mode_o;
  logic [2:0] side_coef_weight_o;
  logic wb_ack_o, wb_err_o, filter_merge_o, coef_share_b_with_a_o, serial_link_enable_o, cfg_write_while_link_o;
  int error_cnt = 0, tests_run = 0;
  always #5 clk_i = ~clk_i;
  eqcb_bank eqcb_bank_inst (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .chb_side_i, .chb_center_i, .cha_side_o, .cha_center_o, .chb_side_o,
    .chb_center_o, .filter_mode_o, .side_coef_weight_o, .filter_merge_o, .coef_share_b_with_a_o,
    .serial_link_enable_o, .cfg_write_while_link_o);
  task automatic results;
    $display("COUNT checks %0d bad %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic check(input string nm, input logic [63:0] s, input logic [63:0] x);
    tests_run++;
    if (s !== x) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, x, s);
    end
  endtask : check
  // Classic cycle held until ack or err is sampled; a hang ends the run
  task automatic bus(input logic [13:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      results();
    end
  endtask : bus
  // Reset value, store, readback with top bit hidden, and tap slot of every register
  task automatic t_taps;
    logic [13:0] a [6] = '{14'h1060, 14'h1068, 14'h1070, 14'h1078, 14'h1080, 14'h108C};
    for (int k = 0; k < 6; k++) begin
      bus(a[k], 1'b0, 32'h0);
      check("reset", {e, q}, 33'h0);
      bus(a[k], 1'b1, k == 4 ? 32'hC20005 : 32'hA800 + k);
      bus(a[k], 1'b0, 32'h0);
      check("readback", q, k == 4 ? 32'hC00005 : 32'hA000 + k);
      if (k == 4) begin
        check("centre", cha_center_o, 18'h20005);
        check("centre rsvd", q[23:18], 6'h30);
      end else begin
        check("slot", cha_side_o[12 * (k > 4 ? 4 : k) +: 12], 12'h800 + k);
        check("side rsvd", q[15:12], 4'hA);
      end
    end
    $display("TEST taps done");
  endtask : t_taps
  // Unmapped place answers with err and disturbs nothing
  task automatic t_unmapped;
    bus(14'h1064, 1'b1, 32'hFFFF);
    check("err wr", e, 1'b1);
    check("err keep", cha_side_o, {12'h805, 12'h803, 12'h802, 12'h801, 12'h800});
    bus(14'h1064, 1'b0, 32'h0);
    check("err rd", {e, q}, {1'b1, 32'h0});
    $display("TEST unmapped done");
  endtask : t_unmapped
  // Sharing on and off, weight clamp; link stays off while configuring
  task automatic t_share;
    check("link off", serial_link_enable_o, 1'b0);
    bus(14'h1000, 1'b1, 32'h7E);
    check("mode", filter_mode_o, 2'h2);
    check("clamp", side_coef_weight_o, 3'h6);
    check("merge", filter_merge_o, 1'b1);
    check("share", coef_share_b_with_a_o, 1'b1);
    check("b side", chb_side_o, {12'h805, 12'h803, 12'h802, 12'h801, 12'h800});
    check("b centre", chb_center_o, 18'h20005);
    bus(14'h1000, 1'b0, 32'h0);
    check("cfg read", q, 32'h7E);
    bus(14'h1000, 1'b1, 32'h14);
    check("weight", side_coef_weight_o, 3'h5);
    check("own side", chb_side_o, chb_side_i);
    check("own centre", {coef_share_b_with_a_o, chb_center_o}, {1'b0, 18'h15A5A});
    $display("TEST share done");
  endtask : t_share
  // Link control and misuse flag: a filter write with the link running stays flagged until cleared
  task automatic t_link;
    bus(14'h1004, 1'b1, 32'h1);
    check("link on", serial_link_enable_o, 1'b1);
    check("no misuse", cfg_write_while_link_o, 1'b0);
    bus(14'h1000, 1'b1, 32'h14);
    check("misuse", cfg_write_while_link_o, 1'b1);
    bus(14'h1004, 1'b0, 32'h0);
    check("ctrl read", q, 32'h3);
    bus(14'h1004, 1'b1, 32'h2);
    check("flag clear", {serial_link_enable_o, cfg_write_while_link_o}, 2'h0);
    $display("TEST link done");
  endtask : t_link
  // Mid-run reset clears every coefficient and configuration field
  task automatic t_reset;
    bus(14'h1000, 1'b1, 32'h40);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check("rst side", cha_side_o, 60'h0);
    check("rst centre", cha_center_o, 18'h0);
    check("rst cfg", {filter_mode_o, side_coef_weight_o, filter_merge_o, coef_share_b_with_a_o}, 7'h0);
    check("rst b", chb_center_o, chb_center_i);
    bus(14'h1080, 1'b0, 32'h0);
    check("rst read", {e, q}, 33'h0);
    $display("TEST reset done");
  endtask : t_reset
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_taps();
    t_unmapped();
    t_share();
    t_link();
    t_reset();
    results();
  end
endmodule : eqcb_bank_tb
bind eqcb_bank eqcb_bank_monitor #(.ADDR_W(ADDR_W)) eqcb_bank_monitor_inst (.clk_i, .rst_i, .wb_adr_i,
  .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .chb_side_i,
  .cha_side_o, .cha_center_o, .chb_side_o, .chb_center_o, .side_coef_weight_o, .coef_share_b_with_a_o);
`default_nettype wire
